// ---- logic/sup_pkg.sv ----
package sup_pkg;

  // ********************************
  // Time base and counters
  // ********************************
  localparam real CLK_PERIOD_NS = 10.0;
  localparam int CNT_W = 21;
  localparam real BLANK_US = 5.0;
  localparam int BLANK_CYC = int'(BLANK_US * 1000.0 / CLK_PERIOD_NS);
  localparam int INIT_CYC = 4;

  // Power-on and recovery delays per group, in ms
  localparam real PWRON_MS_0 = 0.06;
  localparam real PWRON_MS_1 = 1.9;
  localparam real PWRON_MS_2 = 7.7;
  localparam real PWRON_MS_3 = 15.4;
  localparam real RECOV_MS_0 = 0.03;
  localparam real RECOV_MS_1 = 1.3;
  localparam real RECOV_MS_2 = 5.1;
  localparam real RECOV_MS_3 = 10.2;
  localparam logic [3:0][CNT_W-1:0] PWRON_CYC_DEF = {
    CNT_W'(int'(PWRON_MS_3 * 1.0e6 / CLK_PERIOD_NS)), CNT_W'(int'(PWRON_MS_2 * 1.0e6 / CLK_PERIOD_NS)),
    CNT_W'(int'(PWRON_MS_1 * 1.0e6 / CLK_PERIOD_NS)), CNT_W'(int'(PWRON_MS_0 * 1.0e6 / CLK_PERIOD_NS))};
  localparam logic [3:0][CNT_W-1:0] RECOV_CYC_DEF = {
    CNT_W'(int'(RECOV_MS_3 * 1.0e6 / CLK_PERIOD_NS)), CNT_W'(int'(RECOV_MS_2 * 1.0e6 / CLK_PERIOD_NS)),
    CNT_W'(int'(RECOV_MS_1 * 1.0e6 / CLK_PERIOD_NS)), CNT_W'(int'(RECOV_MS_0 * 1.0e6 / CLK_PERIOD_NS))};

  // ********************************
  // Trip levels, percent of nominal feedback
  // ********************************
  localparam logic [3:0][7:0] UV_PCT = {8'h28, 8'h19, 8'h0e, 8'h08};
  localparam logic [7:0] OV_TRIP_PCT = 8'h07;
  localparam logic [7:0] HYS_PCT = 8'h01;

  // ********************************
  // Register map and reset values
  // ********************************
  localparam logic [11:0] CTRL_OFS = 12'h000;
  localparam logic [11:0] STATUS_OFS = 12'h004;
  localparam logic [11:0] ISTAT_OFS = 12'h008;
  localparam logic [11:0] IMASK_OFS = 12'h00c;
  localparam logic [2:0] IMASK_RST = 3'h0;
  localparam int EV_UV = 0;
  localparam int EV_OV = 1;
  localparam int EV_REL = 2;

  // ********************************
  // Types
  // ********************************
  typedef enum logic [2:0] {ST_OFF, ST_INIT, ST_SOFT, ST_PWRON, ST_RUN, ST_BLANK, ST_FAULT, ST_RECOV} sup_st_t;

  typedef struct packed {
    logic uv_below;
    logic uv_clear;
    logic ov_above;
    logic ov_clear;
  } cmp_t;

  typedef struct packed {
    logic [1:0] grp;
    logic [1:0] uv;
  } cfg_t;

  typedef struct packed {
    sup_st_t st;
    logic [CNT_W-1:0] cnt;
    logic uv_fault;
    cfg_t cfg;
    logic rel;
    logic force_low;
    logic [2:0] istat;
    logic [2:0] imask;
    logic [31:0] rdata;
    logic slverr;
  } sup_q_t;

endpackage

// ---- logic/sup_sync.sv ----
`timescale 1ns/1ns
// Two-stage synchroniser for asynchronous pin levels
module sup_sync #(
  parameter int W = 1
) (
  input wire logic pclk,
  input wire logic presetn,
  input wire logic [W-1:0] d,
  output logic [W-1:0] q
);

  logic [1:0][W-1:0] s_q;
  logic [1:0][W-1:0] s_d;

  // Stage one feeds only stage two
  always_comb
  begin
    s_d = {s_q[0], d};
  end

  always_ff @(posedge pclk or negedge presetn)
  begin
    if (!presetn)
      s_q <= '0;
    else
      s_q <= s_d;
  end

  assign q = s_q[1];

endmodule

// ---- logic/sup_cfg_decode.sv ----
`timescale 1ns/1ns
// Maps the decoded resistor selection onto delay group and low trip level
module sup_cfg_decode (
  input wire logic [3:0] sel_code,
  output sup_pkg::cfg_t cfg
);

  always_comb
  begin
    case (sel_code)
      4'h0: cfg = '{grp: 2'h0, uv: 2'h0};
      4'h1: cfg = '{grp: 2'h0, uv: 2'h1};
      4'h2: cfg = '{grp: 2'h0, uv: 2'h2};
      4'h3: cfg = '{grp: 2'h0, uv: 2'h3};
      4'h4: cfg = '{grp: 2'h1, uv: 2'h0};
      4'h5: cfg = '{grp: 2'h1, uv: 2'h1};
      4'h6: cfg = '{grp: 2'h1, uv: 2'h2};
      4'h7: cfg = '{grp: 2'h1, uv: 2'h3};
      4'h8: cfg = '{grp: 2'h2, uv: 2'h1};
      4'h9: cfg = '{grp: 2'h2, uv: 2'h2};
      4'ha: cfg = '{grp: 2'h2, uv: 2'h3};
      4'hb: cfg = '{grp: 2'h3, uv: 2'h0};
      4'hc: cfg = '{grp: 2'h3, uv: 2'h1};
      default: cfg = '{grp: 2'h2, uv: 2'h0};
    endcase
  end

endmodule

// ---- logic/output_voltage_reset_supervisor.sv ----
`timescale 1ns/1ns
// Overview of operation
// - Reset released only in run and blanking states, low in all other states.
// - Reset pin is open drain; only pulls low, partner supplies pull-up.
// - Power-on delay is timed from soft-start done, then reset is released.
// - Feedback below the low trip level pulls reset low after blanking.
// - Undervoltage recovery past level plus hysteresis waits recovery delay, then releases.
// - Feedback above the high trip level pulls reset low after blanking.
// - Overvoltage recovery below level minus hysteresis waits recovery delay, then releases.
// - Selection sampled once in initialization and latched for all later operation.
// - High trip level is fixed, independent of the selection.
// - Excursion must persist through the whole blanking window to pull reset low.
// - Excursion ending within blanking keeps reset released.
// - Lowest four selections give 0.06 ms and 0.03 ms delays.
// - Middle selections give 1.9/1.3, 7.7/5.1, 15.4/10.2 ms delays.
// - Open or large selection gives 7.7/5.1 ms and -8 percent.
// - High trip level sits 7 percent above nominal.
// - Low trip comparison uses 1 percent hysteresis.
module output_voltage_reset_supervisor #(
  parameter logic [3:0][sup_pkg::CNT_W-1:0] PWRON_CYC = sup_pkg::PWRON_CYC_DEF,
  parameter logic [3:0][sup_pkg::CNT_W-1:0] RECOV_CYC = sup_pkg::RECOV_CYC_DEF
) (
  input wire logic pclk,
  input wire logic presetn,
  input wire logic psel,
  input wire logic penable,
  input wire logic pwrite,
  input wire logic [11:0] paddr,
  input wire logic [31:0] pwdata,
  output logic [31:0] prdata,
  output logic pready,
  output logic pslverr,
  input wire logic enable_pin,
  input wire logic softstart_done,
  input wire sup_pkg::cmp_t feedback_cmp,
  input wire logic [3:0] delay_select_pin,
  output logic [7:0] low_trip_level,
  output logic [7:0] high_trip_level,
  output logic [7:0] low_trip_hysteresis,
  output logic [7:0] high_trip_hysteresis,
  input wire logic reset_out_in,
  output logic reset_out_o,
  output logic reset_out_oe_n,
  output logic irq
);

  // ********************************
  // Input synchronisation
  // ********************************
  logic [10:0] sync_q;
  logic en_s;
  logic ss_s;
  sup_pkg::cmp_t cmp_s;
  logic [3:0] sel_s;
  logic pin_s;
  sup_pkg::cfg_t cfg_dec;

  sup_sync #(
    .W(11)
  ) u_sync (
    .pclk(pclk),
    .presetn(presetn),
    .d({enable_pin, softstart_done, feedback_cmp, delay_select_pin, reset_out_in}),
    .q(sync_q)
  );

  assign {en_s, ss_s, cmp_s, sel_s, pin_s} = sync_q;

  sup_cfg_decode u_dec (
    .sel_code(sel_s),
    .cfg(cfg_dec)
  );

  // ********************************
  // State
  // ********************************
  sup_pkg::sup_q_t s_q;
  sup_pkg::sup_q_t s_d;
  logic exc;
  logic recovered;
  logic [sup_pkg::CNT_W-1:0] cnt_inc;
  logic [sup_pkg::CNT_W-1:0] por_last;
  logic [sup_pkg::CNT_W-1:0] rd_last;
  logic [sup_pkg::CNT_W-1:0] blank_last;
  logic [2:0] ev;
  logic wr_acc;
  logic setup;

  // Excursion and recovery from the comparators
  assign exc = cmp_s.uv_below | cmp_s.ov_above;
  assign recovered = s_q.uv_fault ? cmp_s.uv_clear : cmp_s.ov_clear;
  assign cnt_inc = s_q.cnt + 1'b1;
  assign por_last = PWRON_CYC[s_q.cfg.grp] - 1'b1;
  assign rd_last = RECOV_CYC[s_q.cfg.grp] - 1'b1;
  assign blank_last = sup_pkg::CNT_W'(sup_pkg::BLANK_CYC - 1);
  assign wr_acc = psel & penable & pwrite;
  assign setup = psel & ~penable;

  // Sequencer, register file and event capture
  always_comb
  begin
    s_d = s_q;
    ev = 3'h0;
    case (s_q.st)
      sup_pkg::ST_OFF:
      begin
        s_d.cnt = '0;
        if (en_s)
          s_d.st = sup_pkg::ST_INIT;
      end
      sup_pkg::ST_INIT:
      begin
        s_d.cnt = cnt_inc;
        if (s_q.cnt == sup_pkg::CNT_W'(sup_pkg::INIT_CYC - 1))
        begin
          s_d.cfg = cfg_dec;
          s_d.st = sup_pkg::ST_SOFT;
        end
      end
      sup_pkg::ST_SOFT:
      begin
        s_d.cnt = '0;
        if (ss_s)
          s_d.st = sup_pkg::ST_PWRON;
      end
      sup_pkg::ST_PWRON:
      begin
        s_d.cnt = cnt_inc;
        if (s_q.cnt == por_last)
        begin
          s_d.st = sup_pkg::ST_RUN;
          ev[sup_pkg::EV_REL] = 1'b1;
        end
      end
      sup_pkg::ST_RUN:
      begin
        s_d.cnt = '0;
        if (exc)
          s_d.st = sup_pkg::ST_BLANK;
      end
      sup_pkg::ST_BLANK:
      begin
        s_d.cnt = cnt_inc;
        if (!exc)
          s_d.st = sup_pkg::ST_RUN;
        else if (s_q.cnt == blank_last)
        begin
          s_d.st = sup_pkg::ST_FAULT;
          s_d.uv_fault = cmp_s.uv_below;
          ev[sup_pkg::EV_UV] = cmp_s.uv_below;
          ev[sup_pkg::EV_OV] = cmp_s.ov_above;
        end
      end
      sup_pkg::ST_FAULT:
      begin
        s_d.cnt = '0;
        if (recovered && !exc)
          s_d.st = sup_pkg::ST_RECOV;
      end
      sup_pkg::ST_RECOV:
      begin
        s_d.cnt = cnt_inc;
        if (exc)
        begin
          s_d.st = sup_pkg::ST_FAULT;
          s_d.cnt = '0;
          s_d.uv_fault = cmp_s.uv_below;
        end
        else if (s_q.cnt == rd_last)
        begin
          s_d.st = sup_pkg::ST_RUN;
          ev[sup_pkg::EV_REL] = 1'b1;
        end
      end
      default:
        s_d.st = sup_pkg::ST_OFF;
    endcase
    if (!en_s)
      s_d.st = sup_pkg::ST_OFF;
    // Register writes take effect in the access phase
    if (wr_acc && paddr == sup_pkg::CTRL_OFS)
      s_d.force_low = pwdata[0];
    if (wr_acc && paddr == sup_pkg::IMASK_OFS)
      s_d.imask = pwdata[2:0];
    if (wr_acc && paddr == sup_pkg::ISTAT_OFS)
      s_d.istat = s_q.istat & ~pwdata[2:0];
    // Set wins over write-one-to-clear
    s_d.istat = s_d.istat | ev;
    // released only in run or blanking
    s_d.rel = (s_d.st == sup_pkg::ST_RUN || s_d.st == sup_pkg::ST_BLANK) && !s_d.force_low;
    // Read data captured in the setup phase
    if (setup)
    begin
      s_d.slverr = 1'b0;
      case (paddr)
        sup_pkg::CTRL_OFS:
          s_d.rdata = {31'h0000_0000, s_q.force_low};
        sup_pkg::STATUS_OFS:
          s_d.rdata = {20'h0_0000, s_q.cfg, 5'h00, s_q.uv_fault, pin_s, s_q.rel};
        sup_pkg::ISTAT_OFS:
          s_d.rdata = {29'h0000_0000, s_q.istat};
        sup_pkg::IMASK_OFS:
          s_d.rdata = {29'h0000_0000, s_q.imask};
        default:
        begin
          s_d.rdata = 32'h0000_0000;
          s_d.slverr = 1'b1;
        end
      endcase
    end
  end

  always_ff @(posedge pclk or negedge presetn)
  begin
    if (!presetn)
    begin
      s_q.st <= sup_pkg::ST_OFF;
      s_q.cnt <= '0;
      s_q.uv_fault <= 1'b0;
      s_q.cfg <= '0;
      s_q.rel <= 1'b0;
      s_q.force_low <= 1'b0;
      s_q.istat <= 3'h0;
      s_q.imask <= sup_pkg::IMASK_RST;
      s_q.rdata <= 32'h0000_0000;
      s_q.slverr <= 1'b0;
    end
    else
      s_q <= s_d;
  end

  // ********************************
  // Outputs
  // ********************************
  // APB answers with no wait state
  assign pready = 1'b1;
  assign prdata = s_q.rdata;
  assign pslverr = s_q.slverr & psel & penable;
  assign irq = |(s_q.istat & s_q.imask);
  assign reset_out_o = 1'b0;
  assign reset_out_oe_n = s_q.rel;
  assign low_trip_level = sup_pkg::UV_PCT[s_q.cfg.uv];
  assign high_trip_level = sup_pkg::OV_TRIP_PCT;
  assign low_trip_hysteresis = sup_pkg::HYS_PCT;
  assign high_trip_hysteresis = sup_pkg::HYS_PCT;

  // ********************************
  // Assertions
  // ********************************
  a_pin_never_high: assert property (@(posedge pclk) disable iff (!presetn)
    reset_out_o == 1'b0)
    else $error("reset pin driven high");

  a_hold_until_por: assert property (@(posedge pclk) disable iff (!presetn)
    (s_q.st inside {sup_pkg::ST_OFF, sup_pkg::ST_INIT, sup_pkg::ST_SOFT, sup_pkg::ST_PWRON})
    |-> !reset_out_oe_n)
    else $error("reset released before power-on delay");

  a_fault_low: assert property (@(posedge pclk) disable iff (!presetn)
    (s_q.st inside {sup_pkg::ST_FAULT, sup_pkg::ST_RECOV}) |-> !reset_out_oe_n)
    else $error("reset released while out of window");

  a_por_length: assert property (@(posedge pclk) disable iff (!presetn)
    (s_q.st == sup_pkg::ST_RUN && $past(s_q.st) == sup_pkg::ST_PWRON)
    |-> $past(s_q.cnt) == por_last && reset_out_oe_n == !s_q.force_low)
    else $error("power-on delay length wrong");

  a_recov_length: assert property (@(posedge pclk) disable iff (!presetn)
    (s_q.st == sup_pkg::ST_RUN && $past(s_q.st) == sup_pkg::ST_RECOV)
    |-> $past(s_q.cnt) == rd_last)
    else $error("recovery delay length wrong");

  a_blank_length: assert property (@(posedge pclk) disable iff (!presetn)
    (s_q.st == sup_pkg::ST_FAULT && $past(s_q.st) == sup_pkg::ST_BLANK)
    |-> $past(s_q.cnt) == blank_last && $past(exc))
    else $error("trip before blanking elapsed");

  a_glitch_ignored: assert property (@(posedge pclk) disable iff (!presetn)
    (s_q.st == sup_pkg::ST_BLANK && !exc && en_s)
    |=> s_q.st == sup_pkg::ST_RUN && (reset_out_oe_n || s_q.force_low))
    else $error("short excursion not ignored");

  a_uv_trip_flag: assert property (@(posedge pclk) disable iff (!presetn)
    (s_q.st == sup_pkg::ST_BLANK && s_q.cnt == blank_last && cmp_s.uv_below && en_s)
    |=> s_q.istat[sup_pkg::EV_UV] && s_q.uv_fault ##1 !reset_out_oe_n)
    else $error("undervoltage trip not taken");

  a_ov_trip_flag: assert property (@(posedge pclk) disable iff (!presetn)
    (s_q.st == sup_pkg::ST_BLANK && s_q.cnt == blank_last && cmp_s.ov_above && en_s)
    |=> s_q.istat[sup_pkg::EV_OV] && s_q.st == sup_pkg::ST_FAULT)
    else $error("overvoltage trip not taken");

  a_ov_recover: assert property (@(posedge pclk) disable iff (!presetn)
    (s_q.st == sup_pkg::ST_FAULT && !s_q.uv_fault && !cmp_s.ov_clear)
    |=> s_q.st != sup_pkg::ST_RECOV)
    else $error("overvoltage recovery before hysteresis");

  a_cfg_latched: assert property (@(posedge pclk) disable iff (!presetn)
    (s_q.st != sup_pkg::ST_INIT && $past(s_q.st) != sup_pkg::ST_INIT) |-> $stable(s_q.cfg))
    else $error("configuration changed after init");

  a_ov_fixed: assert property (@(posedge pclk) disable iff (!presetn)
    $changed(s_q.cfg) |-> high_trip_level == 8'h07)
    else $error("high trip level follows selection");

  a_uv_recover: assert property (@(posedge pclk) disable iff (!presetn)
    (s_q.st == sup_pkg::ST_FAULT && s_q.uv_fault && !cmp_s.uv_clear)
    |=> s_q.st != sup_pkg::ST_RECOV)
    else $error("undervoltage recovery before hysteresis");

  a_soft_wait: assert property (@(posedge pclk) disable iff (!presetn)
    (s_q.st == sup_pkg::ST_SOFT && !ss_s)
    |=> s_q.st != sup_pkg::ST_PWRON)
    else $error("power-on delay started before soft-start done");

  a_blank_restart: assert property (@(posedge pclk) disable iff (!presetn)
    (s_q.st == sup_pkg::ST_BLANK && $past(s_q.st) != sup_pkg::ST_BLANK)
    |-> s_q.cnt == '0)
    else $error("blanking window not restarted");

  a_run_released: assert property (@(posedge pclk) disable iff (!presetn)
    (s_q.st == sup_pkg::ST_RUN && !s_q.force_low)
    |-> reset_out_oe_n)
    else $error("reset held low while inside window");

  a_uv_flag_sticky: assert property (@(posedge pclk) disable iff (!presetn)
    (s_q.istat[sup_pkg::EV_UV] && !(wr_acc && paddr == sup_pkg::ISTAT_OFS && pwdata[sup_pkg::EV_UV]))
    |=> s_q.istat[sup_pkg::EV_UV])
    else $error("undervoltage flag lost without clear");

endmodule

// ---- verif/mcu_model.sv ----
`timescale 1ns/1ns
// ********************************
// Controller side of the reset line
// ********************************
module mcu_model (
  input wire logic reset_out_o,
  input wire logic reset_out_oe_n,
  output logic reset_line,
  output int reset_count
);
  assign reset_line = (!reset_out_oe_n && !reset_out_o) ? 1'b0 : 1'b1;

  // Counts reset pulses seen by the controller
  initial reset_count = 0;
  always @(negedge reset_line) reset_count <= reset_count + 1;
endmodule

// ---- verif/output_voltage_reset_supervisor_test.sv ----
`timescale 1ns/1ns
module output_voltage_reset_supervisor_test;
  // ********************************
  // Shortened delays and expected tables
  // ********************************
  localparam logic [3:0][sup_pkg::CNT_W-1:0] PW = {21'h0c8, 21'h096, 21'h064, 21'h03c};
  localparam logic [3:0][sup_pkg::CNT_W-1:0] RC = {21'h078, 21'h05a, 21'h03c, 21'h01e};
  localparam logic [1:0] GRP [16] = '{2'h0, 2'h0, 2'h0, 2'h0, 2'h1, 2'h1, 2'h1, 2'h1,
    2'h2, 2'h2, 2'h2, 2'h3, 2'h3, 2'h2, 2'h2, 2'h2};
  localparam logic [7:0] UVP [16] = '{8'h08, 8'h0e, 8'h19, 8'h28, 8'h08, 8'h0e, 8'h19, 8'h28,
    8'h0e, 8'h19, 8'h28, 8'h08, 8'h0e, 8'h08, 8'h08, 8'h08};
  localparam sup_pkg::cmp_t OK = 4'h5;
  localparam sup_pkg::cmp_t UVB = 4'h9;
  localparam sup_pkg::cmp_t UVM = 4'h1;
  localparam sup_pkg::cmp_t OVB = 4'h6;
  localparam sup_pkg::cmp_t OVM = 4'h4;
  localparam int R = int'(RC[0]);

  logic pclk, presetn, psel, penable, pwrite, pready, pslverr, enable_pin, softstart_done;
  logic [11:0] paddr;
  logic [31:0] pwdata, prdata, rd;
  logic [7:0] ltl, htl, lth, hth;
  logic [3:0] sel;
  sup_pkg::cmp_t fb;
  logic reset_line, oe_n, o_drv, irq, er;
  int err_count, samples_checked, n, cnt0, pcnt;

  output_voltage_reset_supervisor #(.PWRON_CYC(PW), .RECOV_CYC(RC)) i_output_voltage_reset_supervisor (
    .pclk(pclk), .presetn(presetn), .psel(psel), .penable(penable), .pwrite(pwrite),
    .paddr(paddr), .pwdata(pwdata), .prdata(prdata), .pready(pready), .pslverr(pslverr),
    .enable_pin(enable_pin), .softstart_done(softstart_done), .feedback_cmp(fb),
    .delay_select_pin(sel), .low_trip_level(ltl), .high_trip_level(htl),
    .low_trip_hysteresis(lth), .high_trip_hysteresis(hth), .reset_out_in(reset_line),
    .reset_out_o(o_drv), .reset_out_oe_n(oe_n), .irq(irq));

  mcu_model i_mcu_model (.reset_out_o(o_drv), .reset_out_oe_n(oe_n), .reset_line(reset_line),
    .reset_count(pcnt));

  // Clock generation
  initial
  begin
    pclk = 1'b0;
    forever #5 pclk = ~pclk;
  end

  // ********************************
  // Tasks
  // ********************************
  task tick(input int k);
    repeat (k) @(posedge pclk);
  endtask

  task chk(input logic [31:0] seen, input logic [31:0] exp);
    samples_checked++;
    if (seen !== exp)
    begin
      err_count++;
      $display("Error at %0t: seen %h expected %h", $time, seen, exp);
    end
  endtask

  // One APB transfer, waits for pready in access phase
  task apb(input logic wr, input logic [11:0] a, input logic [31:0] wd);
    @(posedge pclk);
    psel <= 1'b1;
    penable <= 1'b0;
    pwrite <= wr;
    paddr <= a;
    pwdata <= wd;
    @(posedge pclk);
    penable <= 1'b1;
    @(posedge pclk);
    while (pready !== 1'b1) @(posedge pclk);
    rd = prdata;
    er = pslverr;
    psel <= 1'b0;
    penable <= 1'b0;
  endtask

  // Counts settled cycles until the reset line reaches a level
  task wait_lvl(input logic lvl);
    n = 0;
    @(negedge pclk);
    while (reset_line !== lvl && n < 5000)
    begin
      @(negedge pclk);
      n++;
    end
  endtask

  task pwr_up(input logic [3:0] code);
    int p;
    p = int'(PW[GRP[code]]);
    @(posedge pclk);
    enable_pin <= 1'b0;
    softstart_done <= 1'b0;
    sel <= code;
    tick(8);
    @(negedge pclk);
    chk({31'h0, reset_line}, 32'h0);
    @(posedge pclk);
    enable_pin <= 1'b1;
    tick(12);
    @(negedge pclk);
    chk({31'h0, reset_line}, 32'h0);
    @(posedge pclk);
    softstart_done <= 1'b1;
    wait_lvl(1'b1);
    chk({31'h0, n >= p && n <= p + 8}, 32'h1);
    chk({24'h0, ltl}, {24'h0, UVP[code]});
    apb(1'b0, sup_pkg::STATUS_OFS, 32'h0);
    chk({30'h0, rd[11:10]}, {30'h0, GRP[code]});
  endtask

  // Glitch, real trip, hysteresis hold and recovery
  task fault(input sup_pkg::cmp_t bad, input sup_pkg::cmp_t mid, input int ev);
    cnt0 = pcnt;
    @(posedge pclk);
    fb <= bad;
    tick(400);
    fb <= OK;
    tick(20);
    @(negedge pclk);
    chk({31'h0, reset_line}, 32'h1);
    @(posedge pclk);
    fb <= bad;
    tick(495);
    @(negedge pclk);
    chk({31'h0, reset_line}, 32'h1);
    wait_lvl(1'b0);
    chk({31'h0, n <= 15}, 32'h1);
    chk({24'h0, htl}, 32'h7);
    @(posedge pclk);
    fb <= mid;
    tick(3 * R);
    @(negedge pclk);
    chk({31'h0, reset_line}, 32'h0);
    @(posedge pclk);
    fb <= OK;
    wait_lvl(1'b1);
    chk({31'h0, n >= R && n <= R + 8}, 32'h1);
    chk(pcnt - cnt0, 32'h1);
    apb(1'b0, sup_pkg::ISTAT_OFS, 32'h0);
    chk({31'h0, rd[ev]}, 32'h1);
    apb(1'b0, sup_pkg::STATUS_OFS, 32'h0);
    chk({29'h0, rd[2:0]}, {29'h0, ev == 0, 2'b11});
  endtask

  task end_sim;
    $display("Checks %0d, mismatches %0d", samples_checked, err_count);
    if (err_count == 0 && samples_checked > 0)
      $display("ALL TESTS PASSED");
    else
      $display("TESTS FAILED");
    $finish;
  endtask

  // ********************************
  // Test sequence
  // ********************************
  initial
  begin
    presetn = 1'b0;
    psel = 1'b0;
    penable = 1'b0;
    pwrite = 1'b0;
    paddr = 12'h000;
    pwdata = 32'h0000_0000;
    enable_pin = 1'b0;
    softstart_done = 1'b0;
    fb = OK;
    sel = 4'h0;
    err_count = 0;
    samples_checked = 0;
    tick(6);
    presetn <= 1'b1;
    @(negedge pclk);
    chk({31'h0, oe_n}, 32'h0);
    chk({31'h0, o_drv}, 32'h0);
    chk({31'h0, irq}, 32'h0);
    chk({24'h0, ltl}, 32'h8);
    chk({8'h0, htl, lth, hth}, 32'h0007_0101);
    apb(1'b0, sup_pkg::IMASK_OFS, 32'h0);
    chk(rd, 32'h0);
    $display("Test reset values done");
    for (int c = 0; c < 16; c++)
      pwr_up(4'(c));
    $display("Test selection table done");
    pwr_up(4'h0);
    apb(1'b0, sup_pkg::ISTAT_OFS, 32'h0);
    chk({31'h0, rd[2]}, 32'h1);
    apb(1'b1, sup_pkg::ISTAT_OFS, 32'h7);
    @(posedge pclk);
    sel <= 4'h3;
    tick(20);
    @(negedge pclk);
    chk({24'h0, ltl}, 32'h8);
    apb(1'b1, sup_pkg::IMASK_OFS, 32'h1);
    fault(UVB, UVM, 0);
    @(negedge pclk);
    chk({31'h0, irq}, 32'h1);
    apb(1'b1, sup_pkg::ISTAT_OFS, 32'h7);
    @(negedge pclk);
    chk({31'h0, irq}, 32'h0);
    $display("Test undervoltage done");
    fault(OVB, OVM, 1);
    @(negedge pclk);
    chk({31'h0, irq}, 32'h0);
    apb(1'b1, sup_pkg::ISTAT_OFS, 32'h7);
    apb(1'b0, sup_pkg::ISTAT_OFS, 32'h0);
    chk(rd, 32'h0);
    $display("Test overvoltage done");
    apb(1'b1, sup_pkg::CTRL_OFS, 32'h1);
    @(negedge pclk);
    chk({31'h0, reset_line}, 32'h0);
    apb(1'b0, sup_pkg::CTRL_OFS, 32'h0);
    chk(rd, 32'h1);
    apb(1'b1, sup_pkg::CTRL_OFS, 32'h0);
    @(negedge pclk);
    chk({31'h0, reset_line}, 32'h1);
    $display("Test manual hold done");
    apb(1'b0, 12'h010, 32'h0);
    chk({31'h0, er}, 32'h1);
    chk(rd, 32'h0);
    apb(1'b1, 12'h010, 32'h1);
    chk({31'h0, er}, 32'h1);
    $display("Test unmapped access done");
    end_sim;
  end

  // Watchdog against a hang
  initial
  begin
    #300000;
    err_count++;
    end_sim;
  end
endmodule
